// File: hdl/tnr_dev.sv
// Register bank of the token node controller, facing the host bus.
// Notes on behaviour
// - Host writes zero to undefined bits.
// - Mask bits align with their status flags.
// - Only five named flags may interrupt.
// - Interrupt is OR of flag AND mask.
// - Unmasking a pending flag reasserts interrupt.
// - Clear-flags command clears reconfiguration flag.
// - Reading successor register clears its flag.
// - Hardware reset zeroes the interrupt mask.
// - Data port reaches RAM at pointer.
// - Writing pointer low preloads read data.
// - Probe number sets hit flag when seen.
// - Probe never reports the token successor.
// - Zero own number keeps core asleep.
// - Nonzero number wakes; joining needs transmit enable.
// - Successor updates set the changed flag.
// - Successor register resets to zero.
// - Status resets to 1XX1 0001.
// - Status meanings differ under command chaining.
// - Diagnostic read clears all but two flags.
// - Excess nack clears only on reset/POR-clear.
// - Host writes only defined command codes.
// - Pointer high written before pointer low.
// - Sub-address bits select address seven register.
`timescale 1ns/1ps
`include "tnr_regs.svh"
module tnr_dev
	import tnr_pkg::*;
#(
	parameter int AW = `TNR_RAM_AW
) (
	input  wire logic       mclk,
	input  wire logic       nrst,
	tnr_bus_if.dev          bus,
	input  wire logic [7:0] core_status,
	input  wire logic       core_recon,
	input  wire logic       core_dup,
	input  wire logic       core_seen,
	input  wire logic [7:0] core_seen_id,
	input  wire logic       core_succ_we,
	input  wire logic [7:0] core_succ_id,
	input  wire logic       core_nack_excess,
	output logic            core_awake,
	output logic            core_tx_join,
	output logic            core_chain_en,
	output logic [7:0]      core_setup1,
	output logic [7:0]      core_setup2,
	output logic [7:0]      core_cmd,
	output logic            core_cmd_stb
);
	typedef struct packed {
		logic [7:0]    mask;
		logic [7:0]    conf;
		logic [2:0]    sub;
		logic [7:0]    probe;
		logic [7:0]    own;
		logic [7:0]    succ;
		logic [7:0]    setup1;
		logic [7:0]    setup2;
		logic [7:0]    diag;
		logic [7:0]    ptrh;
		logic [AW-1:0] ptr;
		logic [7:0]    rdata;
		logic          ld;
		logic          ld2;
		logic          rd_q;
		logic          irq;
		logic          awake;
		logic          join_en;
		logic [7:0]    cmd;
		logic          cmd_stb;
	} tnr_dev_t;
	tnr_dev_t s_q, s_d;
	logic [7:0] ram_q;
	logic       ram_we;
	logic       rd_edge;
	logic       wr_stb;
	logic       sw_rst;
	logic [7:0] flags;
	logic [7:0] rd_mux;
	function automatic logic [7:0] sel7(input tnr_dev_t s);
		case (s.sub)
			`TNR_S_PROBE:  sel7 = s.probe;
			`TNR_S_OWN:    sel7 = s.own;
			`TNR_S_SETUP1: sel7 = s.setup1;
			`TNR_S_SUCC:   sel7 = s.succ;
			`TNR_S_SETUP2: sel7 = s.setup2;
			default:       sel7 = 8'h00;
		endcase
	endfunction : sel7
	tnr_ram #(.AW(AW)) tnr_ram_i (
		.mclk  (mclk),
		.we    (ram_we),
		.addr  (s_q.ptr),
		.wdata (bus.wdata),
		.rdata (ram_q)
	);
	assign wr_stb  = bus.cs & bus.wr;
	assign rd_edge = bus.cs & bus.rd & ~s_q.rd_q;
	assign ram_we  = wr_stb & (bus.addr == `TNR_A_DATA);
	assign sw_rst  = s_q.conf[`TNR_B_SWRST];
	// Status flags pass through from the core; reconfiguration is held here.
	assign flags = {core_status[7:3], s_q.diag[`TNR_B_MYRECON], core_status[1:0]};
	always_comb begin
		rd_mux = 8'h00;
		case (bus.addr)
			`TNR_A_STAT: rd_mux = sw_rst ? `TNR_STAT_RST : flags;
			`TNR_A_DIAG: rd_mux = s_q.diag;
			`TNR_A_PTRH: rd_mux = s_q.ptrh;
			`TNR_A_PTRL: rd_mux = s_q.ptr[7:0];
			`TNR_A_DATA: rd_mux = s_q.rdata;
			`TNR_A_SUBA: rd_mux = {5'h00, s_q.sub};
			`TNR_A_CONF: rd_mux = {s_q.conf[7:2], s_q.sub[1:0]};
			default:     rd_mux = sel7(s_q);
		endcase
	end
	always_comb begin
		s_d = s_q;
		s_d.rd_q = bus.cs & bus.rd;
		s_d.cmd_stb = 1'b0;
		s_d.ld = 1'b0;
		// The RAM read is registered, so data for the new pointer appears one cycle after the pointer loads, and the preload waits a cycle.
		s_d.ld2 = s_q.ld;
		if (s_q.ld2) begin
			s_d.rdata = ram_q;
		end
		if (wr_stb) begin
			case (bus.addr)
				`TNR_A_STAT: s_d.mask = bus.wdata & `TNR_IRQ_SRC;
				`TNR_A_DIAG: begin
					s_d.cmd = bus.wdata;
					s_d.cmd_stb = 1'b1;
					if (bus.wdata == `TNR_CMD_CLR || bus.wdata == `TNR_CMD_PORCLR) begin
						s_d.diag[`TNR_B_MYRECON] = 1'b0;
					end
					if (bus.wdata == `TNR_CMD_PORCLR) begin
						s_d.diag[`TNR_B_EXCNACK] = 1'b0;
					end
				end
				`TNR_A_PTRH: s_d.ptrh = bus.wdata;
				`TNR_A_PTRL: begin
					s_d.ptr = AW'({s_q.ptrh, bus.wdata});
					s_d.ld = 1'b1;
				end
				`TNR_A_SUBA: s_d.sub = bus.wdata[2:0];
				`TNR_A_CONF: begin
					s_d.conf = bus.wdata;
					s_d.sub = {1'b0, bus.wdata[1:0]};
				end
				`TNR_A_SEL7: begin
					case (s_q.sub)
						`TNR_S_PROBE:  s_d.probe = bus.wdata;
						`TNR_S_OWN:    s_d.own = bus.wdata;
						`TNR_S_SETUP1: s_d.setup1 = bus.wdata;
						`TNR_S_SETUP2: s_d.setup2 = bus.wdata;
						default:       s_d.own = s_q.own;
					endcase
				end
				default: s_d.cmd_stb = 1'b0;
			endcase
		end
		if (rd_edge && bus.addr == `TNR_A_DIAG) begin
			s_d.diag = s_q.diag & 8'h0A;
		end
		if (rd_edge && bus.addr == `TNR_A_SEL7 && s_q.sub == `TNR_S_SUCC) begin
			s_d.diag[`TNR_B_SUCC] = 1'b0;
		end
		// Hardware events follow the host clears so a set beats a same-cycle clear; software reset comes after and wins.
		if (s_q.awake && core_recon) begin
			s_d.diag[`TNR_B_MYRECON] = 1'b1;
		end
		if (s_q.awake && core_dup) begin
			s_d.diag[`TNR_B_DUP] = 1'b1;
		end
		if (core_seen && core_seen_id == s_q.probe && core_seen_id != s_q.succ) begin
			s_d.diag[`TNR_B_PROBE] = 1'b1;
		end
		if (core_nack_excess) begin
			s_d.diag[`TNR_B_EXCNACK] = 1'b1;
		end
		if (s_q.awake && core_succ_we) begin
			s_d.succ = core_succ_id;
			s_d.diag[`TNR_B_SUCC] = 1'b1;
		end
		if (sw_rst) begin
			s_d.succ = `TNR_ID_RST;
			s_d.diag = 8'h00;
		end
		s_d.awake = (s_q.own != 8'h00);
		s_d.join_en = s_d.awake & s_q.conf[`TNR_B_TRANSMIT_ENABLE_BIT];
		s_d.irq = |({flags[7], 3'b000, s_q.diag[`TNR_B_EXCNACK], s_q.diag[`TNR_B_MYRECON],
			s_q.diag[`TNR_B_SUCC], flags[0]} & s_q.mask);
	end
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			s_q <= '0;
			s_q.mask <= `TNR_MASK_RST;
			s_q.conf <= `TNR_CONF_RST;
			s_q.succ <= `TNR_ID_RST;
		end else begin
			s_q <= s_d;
		end
	end
	assign bus.rdata     = rd_mux;
	assign bus.irq       = s_q.irq;
	assign core_awake    = s_q.awake;
	assign core_tx_join  = s_q.join_en;
	assign core_chain_en = s_q.conf[`TNR_B_CCHEN];
	assign core_setup1   = s_q.setup1;
	assign core_setup2   = s_q.setup2;
	assign core_cmd      = s_q.cmd;
	assign core_cmd_stb  = s_q.cmd_stb;
endmodule : tnr_dev

// File: hdl/tnr_regs.svh
// Register offsets, field positions, reset values and command codes for the token node register bank.
`ifndef TNR_REGS_SVH
`define TNR_REGS_SVH
`define TNR_A_STAT      3'h0
`define TNR_A_DIAG      3'h1
`define TNR_A_PTRH      3'h2
`define TNR_A_PTRL      3'h3
`define TNR_A_DATA      3'h4
`define TNR_A_SUBA      3'h5
`define TNR_A_CONF      3'h6
`define TNR_A_SEL7      3'h7
`define TNR_S_PROBE     3'h0
`define TNR_S_OWN       3'h1
`define TNR_S_SETUP1    3'h2
`define TNR_S_SUCC      3'h3
`define TNR_S_SETUP2    3'h4
`define TNR_B_RI        7
`define TNR_B_EXCNACK   3
`define TNR_B_RECON     2
`define TNR_B_SUCC      1
`define TNR_B_TA        0
`define TNR_B_MYRECON   7
`define TNR_B_DUP       6
`define TNR_B_PROBE     2
`define TNR_B_TRANSMIT_ENABLE_BIT      5
`define TNR_B_CCHEN     6
`define TNR_B_SWRST     7
`define TNR_MASK_RST    8'h00
`define TNR_STAT_RST    8'h91
`define TNR_CONF_RST    8'h18
`define TNR_ID_RST      8'h00
`define TNR_IRQ_SRC     8'h8F
`define TNR_CMD_CLR     8'h1E
`define TNR_CMD_PORCLR  8'h0E
`define TNR_CMD_CLRMASK 8'hF7
`define TNR_RAM_AW      11
`endif

// File: hdl/tnr_pkg.sv
// Types of the host end's state; the token node register bank imports the package but uses none of them.
package tnr_pkg;
	typedef enum logic [1:0] {TNR_IDLE, TNR_WR, TNR_RD} tnr_hstate_t;
	typedef struct packed {
		tnr_hstate_t state;
		logic        cs;
		logic        wr;
		logic        rd;
		logic [2:0]  addr;
		logic [7:0]  wdata;
		logic [7:0]  rdata;
		logic        done;
	} tnr_host_t;
endpackage : tnr_pkg

// File: hdl/tnr_bus_if.sv
// Host bus between the processor end and the register bank.
`timescale 1ns/1ps
interface tnr_bus_if;
	logic       cs;
	logic       wr;
	logic       rd;
	logic [2:0] addr;
	logic [7:0] wdata;
	logic [7:0] rdata;
	logic       irq;
	modport dev  (input cs, input wr, input rd, input addr, input wdata, output rdata, output irq);
	modport host (output cs, output wr, output rd, output addr, output wdata, input rdata, input irq);
endinterface : tnr_bus_if

// File: hdl/tnr_ram.sv
// Packet RAM with one synchronous read and write port.
`timescale 1ns/1ps
module tnr_ram #(
	parameter int AW = 11
) (
	input  wire logic          mclk,
	input  wire logic          we,
	input  wire logic [AW-1:0] addr,
	input  wire logic [7:0]    wdata,
	output logic      [7:0]    rdata
);
	logic [7:0] mem [0:(1<<AW)-1];
	always_ff @(posedge mclk) begin
		if (we) begin
			mem[addr] <= wdata;
		end
		rdata <= mem[addr];
	end
endmodule : tnr_ram

// File: hdl/tnr_host.sv
// Host end: turns one-cycle requests into bus cycles on the register bank.
`timescale 1ns/1ps
`include "tnr_regs.svh"
module tnr_host
	import tnr_pkg::*;
(
	input  wire logic       mclk,
	input  wire logic       nrst,
	tnr_bus_if.host         bus,
	input  wire logic       req,
	input  wire logic       req_wr,
	input  wire logic [2:0] req_addr,
	input  wire logic [7:0] req_wdata,
	output logic            busy,
	output logic            done,
	output logic [7:0]      rdata,
	output logic            irq
);
	tnr_host_t s_q, s_d;
	logic      irq_q;
	always_comb begin
		s_d = s_q;
		s_d.done = 1'b0;
		case (s_q.state)
			TNR_IDLE: begin
				if (req) begin
					s_d.cs = 1'b1;
					s_d.addr = req_addr;
					s_d.wr = req_wr;
					s_d.rd = ~req_wr;
					// caller supplies defined codes with undefined bits zero.
					s_d.wdata = req_wdata;
					s_d.state = req_wr ? TNR_WR : TNR_RD;
				end
			end
			TNR_WR: begin
				s_d.cs = 1'b0;
				s_d.wr = 1'b0;
				s_d.done = 1'b1;
				s_d.state = TNR_IDLE;
			end
			TNR_RD: begin
				s_d.cs = 1'b0;
				s_d.rd = 1'b0;
				s_d.rdata = bus.rdata;
				s_d.done = 1'b1;
				s_d.state = TNR_IDLE;
			end
			default: s_d.state = TNR_IDLE;
		endcase
	end
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			s_q <= '0;
			irq_q <= 1'b0;
		end else begin
			s_q <= s_d;
			irq_q <= bus.irq;
		end
	end
	assign bus.cs    = s_q.cs;
	assign bus.wr    = s_q.wr;
	assign bus.rd    = s_q.rd;
	assign bus.addr  = s_q.addr;
	assign bus.wdata = s_q.wdata;
	assign busy      = (s_q.state != TNR_IDLE);
	assign done      = s_q.done;
	assign rdata     = s_q.rdata;
	assign irq       = irq_q;
endmodule : tnr_host

// File: dv/tnr_bus_checker.sv
// Assertions on the host bus of the token node register bank.
`timescale 1ns/1ps
module tnr_bus_checker (
	input wire logic       mclk,
	input wire logic       nrst,
	input wire logic       cs,
	input wire logic       wr,
	input wire logic       rd,
	input wire logic [2:0] addr,
	input wire logic [7:0] wdata,
	input wire logic [7:0] rdata,
	input wire logic       irq
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!nrst);
	logic hi_seen_q;
	logic hi_seen_d;
	always_comb begin
		hi_seen_d = hi_seen_q;
		if (cs && wr && addr == 3'h2) hi_seen_d = 1'b1;
		else if (cs && wr && addr == 3'h3) hi_seen_d = 1'b0;
	end
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) hi_seen_q <= 1'b0;
		else hi_seen_q <= hi_seen_d;
	end
	sequence s_mask_wr;
		cs && wr && addr == 3'h0;
	endsequence
	sequence s_low_wr;
		cs && wr && addr == 3'h3;
	endsequence
	property p_reset_quiet;
		$rose(nrst) |-> !irq;
	endproperty
	a_reset_quiet: assert property (p_reset_quiet) else $error("irq high after reset");
	property p_mask_unused;
		s_mask_wr ##0 ((wdata & 8'h8F) == 8'h00) |-> ##2 !irq [*2];
	endproperty
	a_mask_unused: assert property (p_mask_unused) else $error("irq without mask");
	property p_undef_zero;
		s_mask_wr |-> (wdata & 8'h70) == 8'h00;
	endproperty
	a_undef_zero: assert property (p_undef_zero) else $error("undefined mask bit set");
	property p_cmd_legal;
		cs && wr && addr == 3'h1 |-> wdata inside {8'h1E, 8'h0E};
	endproperty
	a_cmd_legal: assert property (p_cmd_legal) else $error("illegal command code");
	property p_ptr_order;
		s_low_wr |-> hi_seen_q;
	endproperty
	a_ptr_order: assert property (p_ptr_order) else $error("low pointer before high");
	property p_strobe_single;
		cs |=> !cs;
	endproperty
	a_strobe_single: assert property (p_strobe_single) else $error("select too long");
	property p_dir_one;
		cs |-> (wr ^ rd);
	endproperty
	a_dir_one: assert property (p_dir_one) else $error("bad direction");
	property p_idle;
		!cs |-> !wr && !rd;
	endproperty
	a_idle: assert property (p_idle) else $error("strobe without select");
endmodule : tnr_bus_checker

// File: dv/token_net_host_register_bank_tb.sv
// Testbench joining the host end and the register bank.
`timescale 1ns/1ps
module token_net_host_register_bank_tb;
	logic       mclk;
	logic       nrst;
	logic       req;
	logic       req_wr;
	logic [2:0] req_addr;
	logic [7:0] req_wdata;
	logic       done;
	logic [7:0] rdata;
	logic       irq;
	logic [7:0] core_status;
	logic [4:0] ev;
	logic [7:0] ev_id;
	logic       awake;
	logic       join_en;
	int         num_errors;
	int         samples_checked;
	tnr_bus_if tnr_bus_if_i ();
	tnr_dev tnr_dev_i (.mclk(mclk), .nrst(nrst), .bus(tnr_bus_if_i), .core_status(core_status),
		.core_recon(ev[0]), .core_dup(ev[1]), .core_seen(ev[2]), .core_seen_id(ev_id),
		.core_succ_we(ev[3]), .core_succ_id(ev_id), .core_nack_excess(ev[4]),
		.core_awake(awake), .core_tx_join(join_en), .core_chain_en(), .core_setup1(),
		.core_setup2(), .core_cmd(), .core_cmd_stb());
	tnr_host tnr_host_i (.mclk(mclk), .nrst(nrst), .bus(tnr_bus_if_i), .req(req), .req_wr(req_wr),
		.req_addr(req_addr), .req_wdata(req_wdata), .busy(), .done(done), .rdata(rdata), .irq(irq));
	tnr_bus_checker tnr_bus_checker_i (.mclk(mclk), .nrst(nrst), .cs(tnr_bus_if_i.cs),
		.wr(tnr_bus_if_i.wr), .rd(tnr_bus_if_i.rd), .addr(tnr_bus_if_i.addr),
		.wdata(tnr_bus_if_i.wdata), .rdata(tnr_bus_if_i.rdata), .irq(tnr_bus_if_i.irq));
	initial begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end
	task automatic check(input string nm, input logic [7:0] e, input logic [7:0] g);
		samples_checked++;
		if (g !== e) begin
			$display("Error %s expected %h seen %h", nm, e, g);
			num_errors++;
		end
	endtask : check
	task automatic xfer(input logic w, input logic [2:0] a, input logic [7:0] d);
		int n;
		@(negedge mclk);
		req = 1'b1;
		req_wr = w;
		req_addr = a;
		req_wdata = d;
		@(negedge mclk);
		req = 1'b0;
		n = 0;
		while (done !== 1'b1 && n < 10) begin
			@(negedge mclk);
			n++;
		end
		check("done", 8'h01, {7'h00, done});
	endtask : xfer
	task automatic rd(input logic [2:0] a, input logic [7:0] e, input string nm);
		xfer(1'b0, a, 8'h00);
		check(nm, e, rdata);
	endtask : rd
	task automatic ck_irq(input logic e);
		repeat (4) @(negedge mclk);
		check("irq", {7'h00, e}, {7'h00, irq});
	endtask : ck_irq
	task automatic pulse(input logic [4:0] p, input logic [7:0] id);
		@(negedge mclk);
		ev = p;
		ev_id = id;
		@(negedge mclk);
		ev = 5'h00;
	endtask : pulse
	task automatic finish_test;
		$display("Checks %0d errors %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : finish_test
	initial begin
		{nrst, req, req_wr, req_addr, req_wdata, ev, ev_id} = '0;
		core_status = 8'h91;
		num_errors = 0;
		samples_checked = 0;
		repeat (5) @(negedge mclk);
		nrst = 1'b1;
		check("irq", 8'h00, {7'h00, irq});
		check("awake", 8'h00, {7'h00, awake});
		rd(3'h0, 8'h91, "status");
		xfer(1'b1, 3'h5, 8'h03);
		rd(3'h7, 8'h00, "successor");
		for (int i = 0; i < 4; i++) begin
			xfer(1'b1, 3'h2, 8'(i % 2 + 1));
			xfer(1'b1, 3'h3, 8'h23);
			if (i < 2) xfer(1'b1, 3'h4, 8'hA5 ^ 8'(i));
			else rd(3'h4, 8'hA5 ^ 8'(i - 2), "ram");
		end
		xfer(1'b1, 3'h5, 8'h01);
		xfer(1'b1, 3'h7, 8'h05);
		@(negedge mclk);
		check("awake", 8'h01, {7'h00, awake});
		check("join", 8'h00, {7'h00, join_en});
		xfer(1'b1, 3'h5, 8'h03);
		pulse(5'h08, 8'h2A);
		ck_irq(1'b0);
		xfer(1'b1, 3'h0, 8'h02);
		ck_irq(1'b1);
		xfer(1'b1, 3'h0, 8'h00);
		ck_irq(1'b0);
		xfer(1'b1, 3'h0, 8'h02);
		ck_irq(1'b1);
		rd(3'h1, 8'h02, "diag");
		rd(3'h1, 8'h02, "diag");
		rd(3'h7, 8'h2A, "successor");
		ck_irq(1'b0);
		pulse(5'h10, 8'h00);
		xfer(1'b1, 3'h0, 8'h08);
		ck_irq(1'b1);
		rd(3'h1, 8'h08, "diag");
		xfer(1'b1, 3'h1, 8'h1E);
		ck_irq(1'b1);
		xfer(1'b1, 3'h1, 8'h0E);
		ck_irq(1'b0);
		core_status = 8'h70;
		pulse(5'h02, 8'h00);
		xfer(1'b1, 3'h0, 8'h8F);
		ck_irq(1'b0);
		rd(3'h1, 8'h40, "diag");
		core_status = 8'h71;
		ck_irq(1'b1);
		core_status = 8'hF0;
		ck_irq(1'b1);
		xfer(1'b1, 3'h6, 8'h38);
		@(negedge mclk);
		check("join", 8'h01, {7'h00, join_en});
		xfer(1'b1, 3'h7, 8'h09);
		pulse(5'h04, 8'h09);
		rd(3'h1, 8'h04, "diag");
		xfer(1'b1, 3'h7, 8'h2A);
		pulse(5'h04, 8'h2A);
		rd(3'h1, 8'h00, "diag");
		core_status = 8'h70;
		pulse(5'h01, 8'h00);
		ck_irq(1'b1);
		xfer(1'b1, 3'h1, 8'h1E);
		ck_irq(1'b0);
		xfer(1'b1, 3'h6, 8'h80);
		rd(3'h0, 8'h91, "status");
		xfer(1'b1, 3'h5, 8'h03);
		rd(3'h7, 8'h00, "successor");
		rd(3'h1, 8'h00, "diag");
		finish_test();
	end
	initial begin
		#40000;
		num_errors++;
		finish_test();
	end
endmodule : token_net_host_register_bank_tb
